// *** rtl/cpu_mode_guard_params.svh ***
// Constants for the CPU mode and segment access guard
`ifndef CPU_MODE_GUARD_PARAMS_SVH
`define CPU_MODE_GUARD_PARAMS_SVH
`define SEG_TABLE_BASE_RESET 16'h0000
`define ATTR_REG_RESET 8'h00
`define ATTR_PERM_RESET 8'h55
`define RDATA_IDLE 8'h00
`define ADDR_SEG_LO 8'h00
`define ADDR_SEG_HI 8'h01
`define ADDR_PSU 8'h02
`define ADDR_ATTR 8'h03
`define ADDR_HW_LO 8'h10
`define ADDR_HW_HI 8'h1F
`define ADDR_GEN_LO 8'h20
`define ADDR_GEN_HI 8'h2F
`define PSU_RESET 8'h00
`define PSU_MODE_LSB 0
`define PSU_MODE_MSB 1
`define ATTR_REG_COUNT 4
`define SPECIAL_CALL_ADDR_A 24'h00_FF00
`define SPECIAL_CALL_ADDR_B 24'h00_FF40
`define SUPPRESSED_CALL_ADDR 24'h00_FF80
`define SYS_VECTOR_BASE 24'h00_FE00
`define SYS_VECTOR_MASK 24'hFF_FF80
`define MODE_SYSTEM 2'h0
`define MODE_USER 2'h1
`define STACK_DEPTH 4
`endif

// *** rtl/cpu_mode_guard_pkg.sv ***
// Types for the CPU mode and segment access guard
package cpu_mode_guard_pkg;
  typedef enum logic [1:0] {
    MODE_SYS,
    MODE_USR,
    MODE_RSV2,
    MODE_RSV3
  } cpu_mode_t;

  typedef enum logic [2:0] {
    SFR_SEG_BASE_LO,
    SFR_SEG_BASE_HI,
    SFR_PROC_STATUS_UPPER,
    SFR_ATTR,
    SFR_HW_COMP,
    SFR_GENERAL,
    SFR_NONE
  } sfr_group_t;

  typedef struct packed {
    logic valid;
    logic write;
    logic [7:0] addr;
    logic [7:0] wdata;
  } sfr_req_t;

  typedef struct packed {
    logic call_valid;
    logic [23:0] call_target;
    logic system_vector_entry_call;
    logic exc_take;
    logic return_from_interrupt_instr;
  } flow_evt_t;

  typedef struct packed {
    logic hw_read_ok;
    logic hw_write_ok;
  } seg_rights_t;
endpackage

// *** rtl/sfr_access_check.sv ***
// Access decision for one special function register access
`timescale 1ns/100ps
`include "cpu_mode_guard_params.svh"
module sfr_access_check (
  input wire logic [1:0] mode,
  input wire logic [2:0] group,
  input wire logic write,
  input wire logic [1:0] attr_wr_perm,
  input wire cpu_mode_guard_pkg::seg_rights_t rights,
  output logic allow
);
  always_comb begin
    allow = 1'b0;
    if (group == 3'(cpu_mode_guard_pkg::SFR_SEG_BASE_LO) ||
        group == 3'(cpu_mode_guard_pkg::SFR_SEG_BASE_HI)) begin
      allow = (mode == `MODE_SYSTEM);
    end else if (group == 3'(cpu_mode_guard_pkg::SFR_PROC_STATUS_UPPER)) begin
      allow = write ? (mode == `MODE_SYSTEM) : 1'b1;
    end else if (group == 3'(cpu_mode_guard_pkg::SFR_ATTR)) begin
      allow = write ? attr_wr_perm[mode[0]] : 1'b1;
    end else if (group == 3'(cpu_mode_guard_pkg::SFR_HW_COMP)) begin
      if (mode == `MODE_SYSTEM) begin
        allow = 1'b1;
      end else begin
        allow = write ? rights.hw_write_ok : rights.hw_read_ok;
      end
    end else if (group == 3'(cpu_mode_guard_pkg::SFR_GENERAL)) begin
      allow = 1'b1;
    end
  end
endmodule // sfr_access_check

// *** rtl/cpu_mode_segment_access_guard.sv ***
// CPU mode control and protected register access guard
// Behaviour
// - Segment table base register resets to zero, disabling all segments and user code.
// - No input or register can change the fixed memory partition.
// - Security attribute reset values are constants no agent can override.
// - Security attributes live only in a fixed set of registers.
// - Segmentation configuration writes take effect only in system mode.
// - An attribute register changes only when current mode has write permission.
// - Segment table entries are plain memory, outside this guard.
// - Calling a system vector entry address switches mode to system.
// - Taking an exception or interrupt switches mode to system.
// - Return from interrupt restores the mode saved at entry.
// - Long absolute extended call to special address switches mode to system.
// - Writing mode bits of processor status upper switches mode if permitted.
// - Reads and writes of segmentation registers refused outside system mode.
// - User mode hardware register access follows current segment rights.
// - Calls to suppressed secondary mode addresses behave as ordinary calls.
`timescale 1ns/100ps
`include "cpu_mode_guard_params.svh"
module cpu_mode_segment_access_guard (
  input wire logic clk,
  input wire logic rst_n,
  input wire cpu_mode_guard_pkg::sfr_req_t sfr_req,
  input wire logic [1:0] attr_sel,
  input wire cpu_mode_guard_pkg::flow_evt_t flow,
  input wire cpu_mode_guard_pkg::seg_rights_t rights,
  output logic [1:0] cpu_mode_ff,
  output logic [15:0] seg_table_base_ff,
  output logic [7:0] processor_status_upper_ff,
  output logic [7:0] rdata_ff,
  output logic access_ok_ff,
  output logic access_refused_ff,
  output logic [31:0] attr_regs_ff
);
  localparam logic [7:0] ADDR_SEG_LO = `ADDR_SEG_LO;
  localparam logic [7:0] ADDR_SEG_HI = `ADDR_SEG_HI;
  localparam logic [7:0] ADDR_PSU = `ADDR_PSU;
  localparam logic [7:0] ADDR_ATTR = `ADDR_ATTR;
  localparam logic [7:0] ADDR_HW_LO = `ADDR_HW_LO;
  localparam logic [7:0] ADDR_HW_HI = `ADDR_HW_HI;
  localparam logic [7:0] ADDR_GEN_LO = `ADDR_GEN_LO;
  localparam logic [7:0] ADDR_GEN_HI = `ADDR_GEN_HI;
  localparam int STACK_W = 2 * `STACK_DEPTH;

  logic [2:0] group;
  logic allow;
  logic mode_entry;
  logic quiet;
  logic [1:0] nxt_cpu_mode;
  logic [15:0] nxt_seg_table_base;
  logic [7:0] nxt_psu;
  logic [7:0] nxt_rdata;
  logic nxt_access_ok;
  logic nxt_access_refused;
  logic [31:0] nxt_attr_regs;
  logic [STACK_W-1:0] mode_stack_ff;
  logic [STACK_W-1:0] nxt_mode_stack;
  logic [7:0] attr_perm_ff;
  logic [7:0] nxt_attr_perm;
  logic [1:0] cur_perm;

  // Address decode into fixed register groups
  // Partition bounds have no decode and no register
  // Segment table entries are plain memory, not decoded here
  always_comb begin
    group = 3'(cpu_mode_guard_pkg::SFR_NONE);
    if (sfr_req.addr == ADDR_SEG_LO) begin
      group = 3'(cpu_mode_guard_pkg::SFR_SEG_BASE_LO);
    end else if (sfr_req.addr == ADDR_SEG_HI) begin
      group = 3'(cpu_mode_guard_pkg::SFR_SEG_BASE_HI);
    end else if (sfr_req.addr == ADDR_PSU) begin
      group = 3'(cpu_mode_guard_pkg::SFR_PROC_STATUS_UPPER);
    end else if (sfr_req.addr == ADDR_ATTR) begin
      group = 3'(cpu_mode_guard_pkg::SFR_ATTR);
    end else if (sfr_req.addr >= ADDR_HW_LO && sfr_req.addr <= ADDR_HW_HI) begin
      group = 3'(cpu_mode_guard_pkg::SFR_HW_COMP);
    end else if (sfr_req.addr >= ADDR_GEN_LO && sfr_req.addr <= ADDR_GEN_HI) begin
      group = 3'(cpu_mode_guard_pkg::SFR_GENERAL);
    end
  end

  // Per-register write permission pair: bit0 system, bit1 user
  assign cur_perm = attr_perm_ff[2*attr_sel +: 2];

  sfr_access_check u_check (
    .mode(cpu_mode_ff),
    .group(group),
    .write(sfr_req.write),
    .attr_wr_perm(cur_perm),
    .rights(rights),
    .allow(allow)
  );

  // Mode entry events: vector call, exception, special call
  always_comb begin
    mode_entry = flow.exc_take;
    if (flow.system_vector_entry_call) begin
      mode_entry = 1'b1;
    end
    if (flow.call_valid && (flow.call_target == `SPECIAL_CALL_ADDR_A ||
        flow.call_target == `SPECIAL_CALL_ADDR_B)) begin
      mode_entry = 1'b1;
    end
    if (flow.call_valid && (flow.call_target & `SYS_VECTOR_MASK) == `SYS_VECTOR_BASE) begin
      mode_entry = 1'b1;
    end
    // Suppressed-mode call address falls through as a plain call
  end

  assign quiet = !mode_entry && !flow.return_from_interrupt_instr;

  always_comb begin
    nxt_cpu_mode = cpu_mode_ff;
    nxt_mode_stack = mode_stack_ff;
    nxt_seg_table_base = seg_table_base_ff;
    nxt_psu = processor_status_upper_ff;
    nxt_attr_regs = attr_regs_ff;
    nxt_attr_perm = attr_perm_ff;
    nxt_rdata = `RDATA_IDLE;
    nxt_access_ok = 1'b0;
    nxt_access_refused = 1'b0;
    if (mode_entry) begin
      nxt_mode_stack = {mode_stack_ff[STACK_W-3:0], cpu_mode_ff};
      nxt_cpu_mode = `MODE_SYSTEM;
    end else if (flow.return_from_interrupt_instr) begin
      nxt_cpu_mode = mode_stack_ff[1:0];
      nxt_mode_stack = {`MODE_USER, mode_stack_ff[STACK_W-1:2]};
    end else if (sfr_req.valid) begin
      nxt_access_ok = allow;
      nxt_access_refused = ~allow;
      if (allow && sfr_req.write) begin
        if (group == 3'(cpu_mode_guard_pkg::SFR_SEG_BASE_LO)) begin
          nxt_seg_table_base[7:0] = sfr_req.wdata;
        end else if (group == 3'(cpu_mode_guard_pkg::SFR_SEG_BASE_HI)) begin
          nxt_seg_table_base[15:8] = sfr_req.wdata;
        end else if (group == 3'(cpu_mode_guard_pkg::SFR_PROC_STATUS_UPPER)) begin
          nxt_psu = sfr_req.wdata;
          nxt_cpu_mode = sfr_req.wdata[`PSU_MODE_MSB:`PSU_MODE_LSB];
        end else if (group == 3'(cpu_mode_guard_pkg::SFR_ATTR)) begin
          nxt_attr_regs[8*attr_sel +: 8] = sfr_req.wdata;
          nxt_attr_perm[2*attr_sel +: 2] = sfr_req.wdata[1:0];
        end
      end else if (allow) begin
        if (group == 3'(cpu_mode_guard_pkg::SFR_SEG_BASE_LO)) begin
          nxt_rdata = seg_table_base_ff[7:0];
        end else if (group == 3'(cpu_mode_guard_pkg::SFR_SEG_BASE_HI)) begin
          nxt_rdata = seg_table_base_ff[15:8];
        end else if (group == 3'(cpu_mode_guard_pkg::SFR_PROC_STATUS_UPPER)) begin
          nxt_rdata = processor_status_upper_ff;
        end else if (group == 3'(cpu_mode_guard_pkg::SFR_ATTR)) begin
          nxt_rdata = attr_regs_ff[8*attr_sel +: 8];
        end
      end
    end
  end

  // Mode state registers
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cpu_mode_ff <= `MODE_SYSTEM;
      mode_stack_ff <= '0;
    end else begin
      cpu_mode_ff <= nxt_cpu_mode;
      mode_stack_ff <= nxt_mode_stack;
    end
  end

  // Reset values are constants only; no load path exists
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      seg_table_base_ff <= `SEG_TABLE_BASE_RESET;
      processor_status_upper_ff <= `PSU_RESET;
      attr_regs_ff <= {`ATTR_REG_COUNT{`ATTR_REG_RESET}};
      attr_perm_ff <= `ATTR_PERM_RESET;
    end else begin
      seg_table_base_ff <= nxt_seg_table_base;
      processor_status_upper_ff <= nxt_psu;
      attr_regs_ff <= nxt_attr_regs;
      attr_perm_ff <= nxt_attr_perm;
    end
  end

  // Access response registers
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rdata_ff <= `RDATA_IDLE;
      access_ok_ff <= 1'b0;
      access_refused_ff <= 1'b0;
    end else begin
      rdata_ff <= nxt_rdata;
      access_ok_ff <= nxt_access_ok;
      access_refused_ff <= nxt_access_refused;
    end
  end

  // Segment register checks
  a_seg_write_sys: assert property (@(posedge clk) disable iff (!rst_n)
    ($past(cpu_mode_ff) != `MODE_SYSTEM && !$past(mode_entry)) |->
    $stable(seg_table_base_ff)) else $error("Segment base changed outside system mode");

  a_seg_refuse: assert property (@(posedge clk) disable iff (!rst_n)
    (sfr_req.valid && quiet && cpu_mode_ff != `MODE_SYSTEM &&
     (sfr_req.addr == ADDR_SEG_LO || sfr_req.addr == ADDR_SEG_HI)) |=>
    access_refused_ff) else $error("Segment register access not refused");

  a_seg_sys_ok: assert property (@(posedge clk) disable iff (!rst_n)
    (sfr_req.valid && quiet && cpu_mode_ff == `MODE_SYSTEM &&
     (sfr_req.addr == ADDR_SEG_LO || sfr_req.addr == ADDR_SEG_HI)) |=>
    access_ok_ff) else $error("Segment register access refused in system mode");

  a_seg_lo_write: assert property (@(posedge clk) disable iff (!rst_n)
    (sfr_req.valid && sfr_req.write && quiet && cpu_mode_ff == `MODE_SYSTEM &&
     sfr_req.addr == ADDR_SEG_LO) |=> seg_table_base_ff[7:0] == $past(sfr_req.wdata))
    else $error("Segment base low byte not written");

  // Mode control checks
  a_entry_sys: assert property (@(posedge clk) disable iff (!rst_n)
    (flow.exc_take || flow.system_vector_entry_call) |=> cpu_mode_ff == `MODE_SYSTEM)
    else $error("Mode entry did not reach system mode");

  a_call_special: assert property (@(posedge clk) disable iff (!rst_n)
    (flow.call_valid && (flow.call_target == `SPECIAL_CALL_ADDR_A ||
     flow.call_target == `SPECIAL_CALL_ADDR_B)) |=> cpu_mode_ff == `MODE_SYSTEM)
    else $error("Special call did not reach system mode");

  a_vector_call: assert property (@(posedge clk) disable iff (!rst_n)
    (flow.call_valid && (flow.call_target & `SYS_VECTOR_MASK) == `SYS_VECTOR_BASE) |=>
    cpu_mode_ff == `MODE_SYSTEM) else $error("Vector call did not reach system mode");

  a_stack_push: assert property (@(posedge clk) disable iff (!rst_n)
    mode_entry |=> mode_stack_ff[1:0] == $past(cpu_mode_ff))
    else $error("Mode not saved at entry");

  a_return_restore: assert property (@(posedge clk) disable iff (!rst_n)
    (flow.return_from_interrupt_instr && !mode_entry) |=>
    cpu_mode_ff == $past(mode_stack_ff[1:0])) else $error("Return did not restore mode");

  a_suppressed_call: assert property (@(posedge clk) disable iff (!rst_n)
    (flow.call_valid && flow.call_target == `SUPPRESSED_CALL_ADDR && !flow.exc_take &&
     !flow.system_vector_entry_call && !flow.return_from_interrupt_instr && !sfr_req.valid) |=>
    $stable(cpu_mode_ff)) else $error("Suppressed call changed mode");

  a_status_sys_wr: assert property (@(posedge clk) disable iff (!rst_n)
    (sfr_req.valid && sfr_req.write && quiet && sfr_req.addr == ADDR_PSU &&
     cpu_mode_ff == `MODE_SYSTEM) |=>
    cpu_mode_ff == $past(sfr_req.wdata[`PSU_MODE_MSB:`PSU_MODE_LSB]))
    else $error("Status write did not set mode");

  a_status_user_wr: assert property (@(posedge clk) disable iff (!rst_n)
    (sfr_req.valid && sfr_req.write && quiet && sfr_req.addr == ADDR_PSU &&
     cpu_mode_ff != `MODE_SYSTEM) |=>
    ($stable(cpu_mode_ff) && $stable(processor_status_upper_ff)))
    else $error("Refused status write changed mode");

  // Access response checks
  a_refused_hold: assert property (@(posedge clk) disable iff (!rst_n)
    access_refused_ff |-> ($stable(attr_regs_ff) && $stable(cpu_mode_ff)))
    else $error("Refused write changed state");

  a_event_drops: assert property (@(posedge clk) disable iff (!rst_n)
    (mode_entry || flow.return_from_interrupt_instr) |=>
    !(access_ok_ff || access_refused_ff)) else $error("Access answered during mode event");

  a_resp_excl: assert property (@(posedge clk) disable iff (!rst_n)
    !(access_ok_ff && access_refused_ff))
    else $error("Access both allowed and refused");

  a_refused_rdata: assert property (@(posedge clk) disable iff (!rst_n)
    access_refused_ff |-> rdata_ff == `RDATA_IDLE)
    else $error("Refused access returned data");

  a_unmapped: assert property (@(posedge clk) disable iff (!rst_n)
    (sfr_req.valid && quiet && group == 3'(cpu_mode_guard_pkg::SFR_NONE)) |=>
    access_refused_ff) else $error("Unmapped register access allowed");

  a_attr_perm: assert property (@(posedge clk) disable iff (!rst_n)
    (sfr_req.valid && sfr_req.write && group == 3'(cpu_mode_guard_pkg::SFR_ATTR) &&
     quiet && !cur_perm[cpu_mode_ff[0]]) |=> $stable(attr_regs_ff))
    else $error("Attribute write without permission");

  a_user_hw: assert property (@(posedge clk) disable iff (!rst_n)
    (sfr_req.valid && !sfr_req.write && cpu_mode_ff == `MODE_USER && quiet &&
     group == 3'(cpu_mode_guard_pkg::SFR_HW_COMP)) |=>
    access_ok_ff == $past(rights.hw_read_ok)) else $error("Hardware read ignores rights");

  a_hw_user_wr: assert property (@(posedge clk) disable iff (!rst_n)
    (sfr_req.valid && sfr_req.write && cpu_mode_ff == `MODE_USER && quiet &&
     group == 3'(cpu_mode_guard_pkg::SFR_HW_COMP)) |=>
    access_ok_ff == $past(rights.hw_write_ok)) else $error("Hardware write ignores rights");

  a_hw_sys_ok: assert property (@(posedge clk) disable iff (!rst_n)
    (sfr_req.valid && cpu_mode_ff == `MODE_SYSTEM && quiet &&
     group == 3'(cpu_mode_guard_pkg::SFR_HW_COMP)) |=>
    access_ok_ff) else $error("Hardware access refused in system mode");
endmodule // cpu_mode_segment_access_guard

// *** tb/cpu_core_model.sv ***
// CPU core model issuing register accesses and flow events
`timescale 1ns/100ps
module cpu_core_model (
  input wire logic clk,
  output cpu_mode_guard_pkg::sfr_req_t sfr_req,
  output cpu_mode_guard_pkg::flow_evt_t flow
);
  initial begin
    sfr_req = '0;
    flow = '0;
  end
  // Access held over one rising edge, then released with scrambled fields
  task automatic access(input logic wr, input logic [7:0] a, input logic [7:0] d);
    @(negedge clk);
    sfr_req = '{valid: 1'b1, write: wr, addr: a, wdata: d};
    @(negedge clk);
    sfr_req = '{valid: 1'b0, write: ~wr, addr: ~a, wdata: ~d};
  endtask
  // One-cycle flow pulse
  task automatic event_pulse(input cpu_mode_guard_pkg::flow_evt_t f);
    @(negedge clk);
    flow = f;
    @(negedge clk);
    flow = '{1'b0, ~f.call_target, 1'b0, 1'b0, 1'b0};
  endtask
endmodule // cpu_core_model

// *** tb/tb.sv ***
// Testbench for the CPU mode and segment access guard
`timescale 1ns/100ps
module tb;
  logic clk;
  logic rst_n;
  logic [1:0] attr_sel;
  cpu_mode_guard_pkg::seg_rights_t rights;
  cpu_mode_guard_pkg::sfr_req_t sfr_req;
  cpu_mode_guard_pkg::flow_evt_t flow;
  logic [1:0] cpu_mode;
  logic [15:0] base;
  logic [7:0] psu;
  logic [7:0] rdata;
  logic ok;
  logic refused;
  logic [31:0] attr;
  int failures;
  int num_checks;
  cpu_core_model i_cpu (.clk(clk), .sfr_req(sfr_req), .flow(flow));
  cpu_mode_segment_access_guard i_dut (
    .clk(clk), .rst_n(rst_n), .sfr_req(sfr_req), .attr_sel(attr_sel), .flow(flow),
    .rights(rights), .cpu_mode_ff(cpu_mode), .seg_table_base_ff(base),
    .processor_status_upper_ff(psu), .rdata_ff(rdata), .access_ok_ff(ok),
    .access_refused_ff(refused), .attr_regs_ff(attr)
  );
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  task automatic end_sim();
    if (failures == 0 && num_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      failures++;
      $display("unexpected at %0t: value %h, expected %h", $time, got, exp);
    end
  endtask
  task automatic chk_resp(input logic exp_ok);
    num_checks++;
    if ({ok, refused} !== {exp_ok, ~exp_ok}) begin
      failures++;
      $display("unexpected at %0t: ok/refused %b%b, expected ok %b", $time, ok, refused, exp_ok);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic exp_ok);
    i_cpu.access(1'b1, a, d);
    chk_resp(exp_ok);
  endtask
  task automatic rd(input logic [7:0] a, input logic exp_ok);
    i_cpu.access(1'b0, a, 8'h00);
    chk_resp(exp_ok);
  endtask
  task automatic ev(input logic cv, input logic [23:0] t, input logic sv, input logic ex,
                    input logic rt, input logic [1:0] m);
    i_cpu.event_pulse('{cv, t, sv, ex, rt});
    chk({30'h0, cpu_mode}, {30'h0, m});
  endtask
  initial begin
    #20us;
    failures++;
    end_sim();
  end
  initial begin
    rst_n = 1'b0;
    attr_sel = 2'h0;
    rights = '0;
    failures = 0;
    num_checks = 0;
    repeat (12) @(negedge clk);
    rst_n = 1'b1;
    chk({16'h0, base}, 32'h0000_0000);
    chk(attr, 32'h0000_0000);
    chk({22'h0, psu, cpu_mode}, 32'h0000_0000);
    wr(8'h00, 8'hab, 1'b1);
    wr(8'h01, 8'hcd, 1'b1);
    chk({16'h0, base}, 32'h0000_cdab);
    rd(8'h00, 1'b1);
    chk({24'h0, rdata}, 32'h0000_00ab);
    attr_sel = 2'h1;
    wr(8'h03, 8'h03, 1'b1);
    chk(attr, 32'h0000_0300);
    wr(8'h40, 8'h55, 1'b0);
    wr(8'h20, 8'h5a, 1'b1);
    wr(8'h02, 8'h01, 1'b1);
    chk({30'h0, cpu_mode}, 32'h0000_0001);
    chk({24'h0, psu}, 32'h0000_0001);
    wr(8'h00, 8'h11, 1'b0);
    rd(8'h01, 1'b0);
    chk({24'h0, rdata}, 32'h0000_0000);
    chk({16'h0, base}, 32'h0000_cdab);
    wr(8'h02, 8'h00, 1'b0);
    chk({30'h0, cpu_mode}, 32'h0000_0001);
    attr_sel = 2'h0;
    wr(8'h03, 8'h03, 1'b0);
    attr_sel = 2'h1;
    wr(8'h03, 8'h02, 1'b1);
    chk(attr, 32'h0000_0200);
    rd(8'h10, 1'b0);
    rights.hw_read_ok = 1'b1;
    rd(8'h10, 1'b1);
    wr(8'h10, 8'h01, 1'b0);
    rights.hw_write_ok = 1'b1;
    wr(8'h10, 8'h01, 1'b1);
    ev(1'b0, 24'h00_0000, 1'b0, 1'b1, 1'b0, 2'h0);
    ev(1'b0, 24'h00_0000, 1'b0, 1'b0, 1'b1, 2'h1);
    ev(1'b1, 24'h00_ff80, 1'b0, 1'b0, 1'b0, 2'h1);
    ev(1'b1, 24'h00_ff00, 1'b0, 1'b0, 1'b0, 2'h0);
    wr(8'h02, 8'h01, 1'b1);
    ev(1'b1, 24'h00_ff40, 1'b0, 1'b0, 1'b0, 2'h0);
    wr(8'h02, 8'h01, 1'b1);
    ev(1'b1, 24'h00_fe00, 1'b1, 1'b0, 1'b0, 2'h0);
    wr(8'h02, 8'h01, 1'b1);
    ev(1'b1, 24'h00_fe10, 1'b0, 1'b0, 1'b0, 2'h0);
    end_sim();
  end
endmodule // tb
